// *** hw/mbrw_consts.vh ***
// constants of the register read/write command block: function codes,
// frame fields, length values and exception codes
// assumes frames arrive as a byte stream with the application header first
`ifndef MBRW_CONSTS_VH
`define MBRW_CONSTS_VH

`define MBRW_FC_RD_HOLD   8'h03
`define MBRW_FC_RD_INPUT  8'h04
`define MBRW_FC_WR_SINGLE 8'h06
`define MBRW_ERR_BIT      8'h80

`define MBRW_REQ_LEN      16'h0006
`define MBRW_RD_LEN_BASE  16'h0003
`define MBRW_WR_RSP_LEN   16'h0006
`define MBRW_EXC_LEN      16'h0003
`define MBRW_LAST_ADJ     9'h005

`define MBRW_CNT_MIN      16'h0001
`define MBRW_CNT_MAX      16'h007d

`define MBRW_EXC_FUNC     8'h01
`define MBRW_EXC_ADDR     8'h02
`define MBRW_EXC_VALUE    8'h03

`define MBRW_TCP_PORT     16'h01f6

`define MBRW_REQ_BYTES    5'h0c
`define MBRW_MIN_BYTES    5'h08
`define MBRW_CNT_SAT      5'h0d
`define MBRW_RSP_HDR      9'h009

`endif

// *** hw/mbrw_rx.v ***
// request capture: stores the first twelve bytes of one frame
// assumes a byte stream on the same clock, frame end marked by in_last
`timescale 1ns/1ps
`default_nettype none
`include "mbrw_consts.vh"

module mbrw_rx (
  input  wire        clk,
  input  wire        rst,
  input  wire        in_valid,
  input  wire [7:0]  in_data,
  input  wire        in_last,
  input  wire        take,
  output wire [95:0] frame,
  output reg         done_r,
  output reg  [4:0]  nbytes_r
);

  reg  [4:0] cnt_r;
  wire       acc = in_valid & take;

  genvar i;
  generate
    for (i = 0; i < 12; i = i + 1) begin : g_byte
      reg [7:0] b_r;
      always @(posedge clk or posedge rst) begin
        if (rst)
          b_r <= 8'h00;
        else if (acc && cnt_r == i)
          b_r <= in_data;
      end
      // byte 0 lands in the top lane so fields read big-endian
      assign frame[95-8*i -: 8] = b_r;
    end
  endgenerate

  // count saturates so an overlong frame is still seen as too long
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r    <= 5'h00;
      done_r   <= 1'b0;
      nbytes_r <= 5'h00;
    end else begin
      done_r <= 1'b0;
      if (acc) begin
        if (in_last) begin
          cnt_r    <= 5'h00;
          done_r   <= 1'b1;
          nbytes_r <= (cnt_r == `MBRW_CNT_SAT) ? cnt_r : cnt_r + 5'h01;
        end else if (cnt_r != `MBRW_CNT_SAT) begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** hw/mbrw_regrw.v ***
// register read/write command interpreter: parses one request frame,
// checks it, reads or writes registers and streams back the response
// assumes request and response byte streams and the register store all
// run on MCLK; REG_RD_DATA, REG_VALID and REG_PDO follow REG_ADDR
// combinationally in the same cycle
//
// Functional notes
// - read uses code 03h/04h, length 0006h, start address, count 1..7Dh
// - read reply: length 3+2M, byte count 2M, then M values
// - single write uses code 06h, length 0006h, 16-bit address and value
// - single writes accepted only on process data registers
// - good single write is answered by an exact echo of the request
// - failure reply: length 0003h, code with bit 7 set, exception 01..03
// - transaction identifier copied unchanged into the reply
// - protocol and unit identifiers are zero both ways
// - all multi-byte fields travel most significant byte first
// - frames come on TCP port 502, one connection, no CRC
`timescale 1ns/1ps
`default_nettype none
`include "mbrw_consts.vh"

module mbrw_regrw (
  input  wire        MCLK,
  input  wire        RST,
  input  wire        RX_VALID,
  input  wire [7:0]  RX_DATA,
  input  wire        RX_LAST,
  input  wire [15:0] RX_PORT,
  output wire        RX_READY,
  output wire        TX_VALID,
  output wire [7:0]  TX_DATA,
  output wire        TX_LAST,
  input  wire        TX_READY,
  output wire [15:0] REG_ADDR,
  input  wire [15:0] REG_RD_DATA,
  input  wire        REG_VALID,
  input  wire        REG_PDO,
  output wire        REG_WR_STB,
  output wire [15:0] REG_WR_DATA
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_SCAN = 3'd1;
  localparam [2:0] S_WR   = 3'd2;
  localparam [2:0] S_LOAD = 3'd3;
  localparam [2:0] S_SEND = 3'd4;

  wire [95:0] frame;
  wire        done;
  wire [4:0]  nbytes;

  reg  [2:0]  state_r;
  reg  [15:0] tid_r;
  reg  [7:0]  fc_r;
  reg  [15:0] start_r;
  reg  [15:0] addr_r;
  reg  [15:0] val_r;
  reg  [6:0]  left_r;
  reg         err_r;
  reg  [7:0]  exc_r;
  reg  [15:0] rsp_len_r;
  reg  [8:0]  idx_r;
  reg  [7:0]  lo_r;
  reg         port_bad_r;
  reg         tx_valid_r;
  reg  [7:0]  tx_data_r;
  reg         tx_last_r;
  reg         wr_stb_r;
  reg  [15:0] wr_data_r;
  reg  [7:0]  byte_nxt;

  assign RX_READY    = (state_r == S_IDLE);
  assign TX_VALID    = tx_valid_r;
  assign TX_DATA     = tx_data_r;
  assign TX_LAST     = tx_last_r;
  assign REG_ADDR    = addr_r;
  assign REG_WR_STB  = wr_stb_r;
  assign REG_WR_DATA = wr_data_r;

  mbrw_rx u_rx (
    .clk      (MCLK),
    .rst      (RST),
    .in_valid (RX_VALID),
    .in_data  (RX_DATA),
    .in_last  (RX_LAST),
    .take     (RX_READY),
    .frame    (frame),
    .done_r   (done),
    .nbytes_r (nbytes)
  );

  // request fields, high byte first on the wire
  wire [15:0] f_tid  = frame[95:80];
  wire [15:0] f_pid  = frame[79:64];
  wire [15:0] f_len  = frame[63:48];
  wire [7:0]  f_uid  = frame[47:40];
  wire [7:0]  f_fc   = frame[39:32];
  wire [15:0] f_addr = frame[31:16];
  wire [15:0] f_val  = frame[15:0];

  wire        is_rd   = (f_fc == `MBRW_FC_RD_HOLD) || (f_fc == `MBRW_FC_RD_INPUT);
  wire        is_wr   = (f_fc == `MBRW_FC_WR_SINGLE);
  wire        f_drop  = (nbytes < `MBRW_MIN_BYTES) || (f_pid != 16'h0000) ||
                        (f_uid != 8'h00) || port_bad_r;
  wire        cnt_bad = (f_val < `MBRW_CNT_MIN) || (f_val > `MBRW_CNT_MAX);
  wire        rsp_wr  = (fc_r == `MBRW_FC_WR_SINGLE);
  wire [8:0]  sel     = (state_r == S_SEND) ? idx_r + 9'h001 : 9'h000;
  wire [8:0]  dsel    = sel - `MBRW_RSP_HDR;
  wire [8:0]  last_ix = rsp_len_r[8:0] + `MBRW_LAST_ADJ;
  wire [7:0]  bcount  = {left_r, 1'b0};
  wire        hs      = tx_valid_r & TX_READY;
  wire        rd_step = !rsp_wr && !err_r && (sel >= `MBRW_RSP_HDR) && !dsel[0];
  // alignment is only checked where the address maps onto process data
  wire        scan_bad = !REG_VALID || (REG_PDO && start_r[0]);

  // response byte at position sel
  always @* begin
    byte_nxt = 8'h00;
    case (sel)
      9'd0: byte_nxt = tid_r[15:8];
      9'd1: byte_nxt = tid_r[7:0];
      9'd2: byte_nxt = 8'h00;
      9'd3: byte_nxt = 8'h00;
      9'd4: byte_nxt = rsp_len_r[15:8];
      9'd5: byte_nxt = rsp_len_r[7:0];
      9'd6: byte_nxt = 8'h00;
      9'd7: byte_nxt = err_r ? (fc_r | `MBRW_ERR_BIT) : fc_r;
      9'd8: begin
        if (err_r)
          byte_nxt = exc_r;
        else if (rsp_wr)
          byte_nxt = start_r[15:8];
        else
          byte_nxt = bcount;
      end
      9'd9: byte_nxt = rsp_wr ? start_r[7:0] : REG_RD_DATA[15:8];
      9'd10: byte_nxt = rsp_wr ? val_r[15:8] : lo_r;
      9'd11: byte_nxt = rsp_wr ? val_r[7:0] : REG_RD_DATA[15:8];
      default: byte_nxt = dsel[0] ? lo_r : REG_RD_DATA[15:8];
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r    <= S_IDLE;
      tid_r      <= 16'h0000;
      fc_r       <= 8'h00;
      start_r    <= 16'h0000;
      addr_r     <= 16'h0000;
      val_r      <= 16'h0000;
      left_r     <= 7'h00;
      err_r      <= 1'b0;
      exc_r      <= 8'h00;
      rsp_len_r  <= 16'h0000;
      idx_r      <= 9'h000;
      lo_r       <= 8'h00;
      port_bad_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_last_r  <= 1'b0;
      wr_stb_r   <= 1'b0;
      wr_data_r  <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      if (RX_VALID && RX_READY && RX_PORT != `MBRW_TCP_PORT)
        port_bad_r <= 1'b1;
      case (state_r)
        S_IDLE: begin
          if (done) begin
            // a byte of the next frame taken this cycle keeps its mark
            port_bad_r <= RX_VALID && (RX_PORT != `MBRW_TCP_PORT);
            tid_r      <= f_tid;
            fc_r       <= f_fc;
            start_r    <= f_addr;
            addr_r     <= f_addr;
            val_r      <= f_val;
            left_r     <= f_val[6:0];
            err_r      <= 1'b0;
            rsp_len_r  <= `MBRW_EXC_LEN;
            if (f_drop) begin
              // frames under eight bytes, with nonzero protocol or unit identifiers, or from another port get no answer at all
              state_r <= S_IDLE;
            end else if (!is_rd && !is_wr) begin
              err_r   <= 1'b1;
              exc_r   <= `MBRW_EXC_FUNC;
              state_r <= S_LOAD;
            end else if (f_len != `MBRW_REQ_LEN || nbytes != `MBRW_REQ_BYTES) begin
              err_r   <= 1'b1;
              exc_r   <= `MBRW_EXC_VALUE;
              state_r <= S_LOAD;
            end else if (is_wr) begin
              state_r <= S_WR;
            end else if (cnt_bad) begin
              err_r   <= 1'b1;
              exc_r   <= `MBRW_EXC_VALUE;
              state_r <= S_LOAD;
            end else begin
              state_r <= S_SCAN;
            end
          end
        end
        S_SCAN: begin
          // every address is checked before the first byte goes out
          if (scan_bad) begin
            err_r   <= 1'b1;
            exc_r   <= `MBRW_EXC_ADDR;
            state_r <= S_LOAD;
          end else if (left_r == 7'h01) begin
            addr_r    <= start_r;
            left_r    <= val_r[6:0];
            rsp_len_r <= `MBRW_RD_LEN_BASE + {8'h00, val_r[6:0], 1'b0};
            state_r   <= S_LOAD;
          end else begin
            left_r <= left_r - 7'h01;
            addr_r <= addr_r + 16'h0001;
          end
        end
        S_WR: begin
          if (REG_VALID && REG_PDO) begin
            wr_stb_r  <= 1'b1;
            wr_data_r <= val_r;
            rsp_len_r <= `MBRW_WR_RSP_LEN;
          end else begin
            err_r   <= 1'b1;
            exc_r   <= `MBRW_EXC_ADDR;
          end
          state_r <= S_LOAD;
        end
        S_LOAD: begin
          tx_valid_r <= 1'b1;
          tx_data_r  <= byte_nxt;
          tx_last_r  <= 1'b0;
          idx_r      <= 9'h000;
          state_r    <= S_SEND;
        end
        S_SEND: begin
          if (hs) begin
            if (tx_last_r) begin
              tx_valid_r <= 1'b0;
              tx_last_r  <= 1'b0;
              state_r    <= S_IDLE;
            end else begin
              idx_r     <= sel;
              tx_data_r <= byte_nxt;
              tx_last_r <= (sel == last_ix);
              if (rd_step) begin
                lo_r   <= REG_RD_DATA[7:0];
                addr_r <= addr_r + 16'h0001;
              end
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** dv/mbrw_regmodel.sv ***
// register store seen by the command block: read data, existence and process data flags
// assumes address and strobe come from the block on MCLK; answers in the same cycle
`timescale 1ns/1ps
`default_nettype none
module mbrw_regmodel (
  input  wire logic        MCLK,
  input  wire logic [15:0] addr,
  input  wire logic        stb,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             valid,
  output logic             pdo
);
  logic [15:0] mem [256];
  // only the low address byte selects storage, so wide address sweeps alias
  initial for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
  assign valid = addr < 16'h4000;
  assign pdo   = addr[13];
  assign rdata = mem[addr[7:0]];
  always @(posedge MCLK) if (stb) mem[addr[7:0]] <= wdata;
endmodule
`default_nettype wire

// *** dv/mbrw_regrw_assertions.sv ***
// timing checker for the register read/write command block
// assumes it is bound to mbrw_regrw and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module mbrw_regrw_assertions (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       RX_VALID,
  input wire logic       RX_LAST,
  input wire logic       RX_READY,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_LAST,
  input wire logic       TX_READY,
  input wire logic       REG_VALID,
  input wire logic       REG_PDO,
  input wire logic       REG_WR_STB
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  a_busy_tx: assert property (TX_VALID |-> !RX_READY) else $error("ready while replying");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA)
    && $stable(TX_LAST)) else $error("reply byte not held");
  a_stb_pulse: assert property (REG_WR_STB |=> !REG_WR_STB) else $error("long strobe");
  a_stb_pdo: assert property (REG_WR_STB |-> REG_PDO && REG_VALID) else $error("bad write");
  a_stb_busy: assert property (REG_WR_STB |-> !RX_READY) else $error("write when idle");
  a_stb_reply: assert property (REG_WR_STB |=> TX_VALID) else $error("no echo");
  a_last_frees: assert property (TX_VALID && TX_READY && TX_LAST |=> RX_READY && !TX_VALID)
    else $error("not idle after reply");
  // the cycle after a frame end is the decision cycle, where leaving idle is legal
  a_idle_stays: assert property (RX_READY && !(RX_VALID && RX_LAST)
    && !$past(RX_VALID && RX_READY && RX_LAST) |=> RX_READY)
    else $error("left idle mid frame");
  c_write: cover property (REG_WR_STB);
  c_reply: cover property (TX_VALID && TX_READY && TX_LAST);
  c_frame: cover property (RX_VALID && RX_READY && RX_LAST);
endmodule
bind mbrw_regrw mbrw_regrw_assertions u_chk (.MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID),
  .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_LAST(TX_LAST), .TX_READY(TX_READY), .REG_VALID(REG_VALID), .REG_PDO(REG_PDO),
  .REG_WR_STB(REG_WR_STB));
`default_nettype wire

// *** dv/mbrw_regrw_tb.sv ***
// self-checking bench for the register read/write command block
// drives request frames, stalls the reply sink at random and checks every byte
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module mbrw_regrw_tb;
  logic        MCLK = 0, RST = 1, rx_v = 0, rx_l = 0, tx_r = 0;
  logic [7:0]  rx_d = 8'h00, b;
  logic [15:0] port = 16'h01f6, sh [256];
  logic        RX_READY, TX_VALID, TX_LAST, REG_VALID, REG_PDO, REG_WR_STB;
  logic [7:0]  TX_DATA;
  logic [15:0] REG_ADDR, REG_RD_DATA, REG_WR_DATA;
  logic [7:0]  q_exp [$];
  int          n_fail = 0, n_tests = 0;
  initial forever #2.5 MCLK = ~MCLK;
  mbrw_regrw DUT (.MCLK(MCLK), .RST(RST), .RX_VALID(rx_v), .RX_DATA(rx_d), .RX_LAST(rx_l),
    .RX_PORT(port), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_LAST(TX_LAST), .TX_READY(tx_r), .REG_ADDR(REG_ADDR), .REG_RD_DATA(REG_RD_DATA),
    .REG_VALID(REG_VALID), .REG_PDO(REG_PDO), .REG_WR_STB(REG_WR_STB),
    .REG_WR_DATA(REG_WR_DATA));
  mbrw_regmodel u_store (.MCLK(MCLK), .addr(REG_ADDR), .stb(REG_WR_STB), .wdata(REG_WR_DATA),
    .rdata(REG_RD_DATA), .valid(REG_VALID), .pdo(REG_PDO));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic void hdr(logic [15:0] t, l, logic [7:0] f);
    q_exp = {t[15:8], t[7:0], 8'h00, 8'h00, l[15:8], l[7:0], 8'h00, f};
  endfunction
  task automatic run(logic [15:0] t, logic [7:0] u, f, logic [15:0] a, v, l);
    logic [95:0] fr;
    int          k;
    fr = {t, 16'h0000, l, u, f, a, v};
    for (int i = 0; i < 12; i++) begin
      rx_v <= 1'b1;
      rx_d <= fr[95 - 8 * i -: 8];
      rx_l <= (i == 11);
      @(posedge MCLK);
      while (RX_READY !== 1'b1) @(posedge MCLK);
    end
    rx_v <= 1'b0;
    rx_l <= 1'b0;
    rx_d <= ~rx_d;
    k = 0;
    while (q_exp.size() > 0 && k < 3000) begin
      tx_r <= ($urandom % 4) != 0;
      @(posedge MCLK);
      k++;
      if (TX_VALID === 1'b1 && tx_r === 1'b1) begin
        b = q_exp.pop_front();
        `CHK("reply byte", b, TX_DATA)
        `CHK("last flag", q_exp.size() == 0, TX_LAST)
      end
    end
    if (k >= 3000) `CHK("reply timeout", 1'b0, 1'b1)
    repeat (6) @(posedge MCLK);
    `CHK("idle after frame", 2'b10, {RX_READY, TX_VALID})
    $display("test fc %h addr %h done", f, a);
  endtask
  task automatic rd(logic [7:0] f, logic [15:0] a, m);
    logic [15:0] t;
    t = 16'($urandom);
    hdr(t, 16'h0003 + 16'(2 * m), f);
    q_exp.push_back(8'(2 * m));
    for (int i = 0; i < m; i++) q_exp = {q_exp, sh[8'(a + i)][15:8], sh[8'(a + i)][7:0]};
    run(t, 8'h00, f, a, m, 16'h0006);
  endtask
  task automatic wr(logic [15:0] a, v);
    logic [15:0] t;
    t = 16'($urandom);
    hdr(t, 16'h0006, 8'h06);
    q_exp = {q_exp, a[15:8], a[7:0], v[15:8], v[7:0]};
    sh[a[7:0]] = v;
    run(t, 8'h00, 8'h06, a, v, 16'h0006);
    `CHK("write port", {a, v}, {REG_ADDR, REG_WR_DATA})
  endtask
  task automatic ex(logic [7:0] f, logic [15:0] a, v, l, logic [7:0] c);
    logic [15:0] t;
    t = 16'($urandom);
    hdr(t, 16'h0003, f | 8'h80);
    q_exp.push_back(c);
    run(t, 8'h00, f, a, v, l);
  endtask
  initial begin
    logic [15:0] a;
    for (int i = 0; i < 256; i++) sh[i] = {i[7:0], ~i[7:0]};
    void'($urandom(82));
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    rd(8'h03, 16'h0100, 16'h007d);
    ex(8'h03, 16'h0100, 16'h007e, 16'h0006, 8'h03);
    ex(8'h04, 16'h0100, 16'h0000, 16'h0006, 8'h03);
    ex(8'h04, 16'h2001, 16'h0002, 16'h0006, 8'h02);
    ex(8'h03, 16'h3ffe, 16'h0003, 16'h0006, 8'h02);
    ex(8'h06, 16'h0010, 16'h1234, 16'h0006, 8'h02);
    ex(8'h06, 16'h5000, 16'h1234, 16'h0006, 8'h02);
    rd(8'h03, 16'h0010, 16'h0001);
    ex(8'h05, 16'h0000, 16'h0001, 16'h0006, 8'h01);
    ex(8'h10, 16'h0000, 16'h0001, 16'h0006, 8'h01);
    ex(8'h06, 16'h2002, 16'h0001, 16'h0007, 8'h03);
    wr(16'h2000, 16'hffff);
    wr(16'h3ffe, 16'h0000);
    rd(8'h04, 16'h3ffe, 16'h0001);
    run(16'h0001, 8'h01, 8'h03, 16'h0100, 16'h0001, 16'h0006);
    port <= 16'h01f7;
    run(16'h0002, 8'h00, 8'h03, 16'h0100, 16'h0001, 16'h0006);
    port <= 16'h01f6;
    for (int n = 0; n < 24; n++) begin
      a = 16'($urandom) & 16'h3f0e;
      if (n % 3 == 0) wr(a | 16'h2000, 16'($urandom));
      else rd(($urandom % 2) ? 8'h04 : 8'h03, a, 16'($urandom % 8 + 1));
    end
    conclude;
  end
  // longest run is well under 10000 cycles, so 80000 means a hang
  initial begin
    #(5 * 80000);
    n_fail++;
    $display("watchdog expired");
    conclude;
  end
endmodule
`default_nettype wire
